// ### logic/crs_map.vh
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
// ****************************************
// Clock rate
// ****************************************
`define CRS_CLK_MHZ 125
// ****************************************
// Pulse widths in bus clocks
// ****************************************
`define CRS_MIN_PULSE_BCLK 2
`define CRS_LINT_EDGE_PULSE_BCLK 6
`define CRS_PWROK_LOW_BCLK 10
// ****************************************
// Reset and straps
// ****************************************
`define CRS_STRAP_SETUP_BCLK 4
`define CRS_STRAP_HOLD_MIN_BCLK 2
`define CRS_STRAP_HOLD_MAX_BCLK 20
`define CRS_STRAP_HOLD_BCLK 10
`define CRS_RESET_HOLD_US 1000
`define CRS_RESET_HOLD_CYC (`CRS_RESET_HOLD_US * `CRS_CLK_MHZ)
// ****************************************
// Low power sequencing
// ****************************************
`define CRS_PLL_LOCK_US 30
`define CRS_PLL_LOCK_CYC (`CRS_PLL_LOCK_US * `CRS_CLK_MHZ)
`define CRS_ACK_TO_STOP_BCLK 100
`define CRS_ACK_TO_SLEEP_BCLK 100
`define CRS_SLEEP_TO_STOP_BCLK 10
`define CRS_UNSLEEP_HOLD_BCLK 10
`define CRS_UNHALT_HOLD_BCLK 8
// ****************************************
// Widths and irq bus clock
// ****************************************
`define CRS_TIMER_W 17
`define CRS_AGE_W 3
`define CRS_IRQCLK_HALF 2
`endif

// ### logic/crs_cycle_timer.v
`timescale 1ns/10ps
module crs_cycle_timer #(
	parameter W = 17
) (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire ce_in,
	input wire load_in,
	input wire [W-1:0] value_in,
	output wire done_out
);
	reg [W-1:0] count;

	assign done_out = (count == {W{1'b0}});

	// ****************************************
	// Down counter, reload wins over count
	// ****************************************
	always @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			count <= {W{1'b0}};
		else if (ce_in)
		begin
			if (load_in)
				count <= value_in;
			else if (count != {W{1'b0}})
				count <= count - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ### logic/crs_pulse_keeper.v
`timescale 1ns/10ps
module crs_pulse_keeper #(
	parameter W = 1,
	parameter CW = 3,
	parameter [W-1:0] INIT = {W{1'b1}}
) (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire ce_in,
	input wire freeze_in,
	input wire [CW-1:0] min_in,
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);
	reg [CW-1:0] age;

	// ****************************************
	// Level change only after min width held
	// ****************************************
	// Any bit change restarts the shared age; conservative per bit
	always @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			q_out <= INIT;
			age <= {CW{1'b1}};
		end
		else if (ce_in)
		begin
			if ((d_in != q_out) && (age >= min_in) && !freeze_in)
			begin
				q_out <= d_in;
				age <= {{(CW-1){1'b0}}, 1'b1};
			end
			else if (age != {CW{1'b1}})
				age <= age + {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ### logic/crs_sequencer.v
`timescale 1ns/10ps
`include "crs_map.vh"
// Summary of operation
// - Inputs to processor held two clocks minimum
// - Edge-mode local irq lines held six clocks
// - Power-ok low ten clocks before reasserting
// - Power-ok rises after supplies, ten clocks
// - Settled clock waives ten-clock power-ok wait
// - Straps stable four clocks before release
// - Straps held two to twenty after release
// - Irq clock 31.25 MHz; if strapped low, stops with the bus clock in deep halt only
// - Clock runs 100 after ack before stop
// - Inputs stable by ack cycle completion
// - Halt request held until PLL lock
// - Inputs held eight clocks after halt release
// - Quick halt: only reset, priority may change
// - Sleep request 100 clocks after ack
// - Inputs stable when sleep request asserts
// - Clock runs ten clocks after sleep request
// - Sleep request held until PLL lock
// - Halt held ten clocks after sleep release
// - Inputs held ten clocks after sleep release
// - Sleep: only reset may change
module crs_sequencer #(
	parameter RESET_HOLD_CYC = `CRS_RESET_HOLD_CYC,
	parameter STRAP_HOLD = `CRS_STRAP_HOLD_BCLK
) (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire ce_in,
	input wire supplies_ok_in,
	input wire fast_settle_in,
	input wire warm_reset_in,
	input wire lp_req_in,
	input wire lp_sleep_in,
	input wire lp_deep_in,
	input wire wake_in,
	input wire stop_ack_in,
	input wire [10:0] strap_address_in,
	input wire strap_bus_request0_strap_in,
	input wire strap_flush_n_in,
	input wire strap_init_n_in,
	input wire strap_irq_data0_in,
	input wire cache_flush_n_in,
	input wire soft_init_n_in,
	input wire prio_bus_req_n_in,
	input wire [1:0] local_irq_in,
	input wire lint_edge_mode_in,
	output reg power_ok_out,
	output reg cpu_reset_n_out,
	output reg bclk_run_out,
	output reg clock_halt_request_n_out,
	output reg sleep_request_n_out,
	output wire [10:0] strap_address_lines_out,
	output wire strap_address_lines_oe_out,
	output wire bus_request0_strap_out,
	output wire bus_request0_strap_oe_out,
	output wire irq_bus_data0_out,
	output wire irq_bus_data0_oe_out,
	output wire cache_flush_n_out,
	output wire soft_init_n_out,
	output wire priority_bus_request_n_out,
	output wire [1:0] local_irq_pins_out,
	output reg irq_bus_clock_out,
	output wire ready_out,
	output wire lp_active_out
);
	// ****************************************
	// States
	// ****************************************
	localparam [11:0] ST_OFF = 12'h001;
	localparam [11:0] ST_SETTLE = 12'h002;
	localparam [11:0] ST_RST_HOLD = 12'h004;
	localparam [11:0] ST_STRAP = 12'h008;
	localparam [11:0] ST_RUN = 12'h010;
	localparam [11:0] ST_WAIT_ACK = 12'h020;
	localparam [11:0] ST_ACK_GAP = 12'h040;
	localparam [11:0] ST_SLP_ENTER = 12'h080;
	localparam [11:0] ST_HALTED = 12'h100;
	localparam [11:0] ST_PLL_LOCK = 12'h200;
	localparam [11:0] ST_UNSLEEP = 12'h400;
	localparam [11:0] ST_UNHALT = 12'h800;
	localparam TW = `CRS_TIMER_W;
	localparam AW = `CRS_AGE_W;
	localparam [TW-1:0] T_PWROK = `CRS_PWROK_LOW_BCLK;
	localparam [TW-1:0] T_SETUP = `CRS_STRAP_SETUP_BCLK;
	localparam [TW-1:0] T_RST = RESET_HOLD_CYC[TW-1:0];
	localparam [TW-1:0] T_STRAP = STRAP_HOLD[TW-1:0];
	localparam [TW-1:0] T_LOCK = `CRS_PLL_LOCK_CYC;
	localparam [TW-1:0] T_ACK_STOP = `CRS_ACK_TO_STOP_BCLK;
	localparam [TW-1:0] T_ACK_SLP = `CRS_ACK_TO_SLEEP_BCLK;
	localparam [TW-1:0] T_SLP_STOP = `CRS_SLEEP_TO_STOP_BCLK;
	localparam [TW-1:0] T_UNSLP = `CRS_UNSLEEP_HOLD_BCLK;
	localparam [TW-1:0] T_UNHALT = `CRS_UNHALT_HOLD_BCLK;
	localparam [AW-1:0] A_MIN = `CRS_MIN_PULSE_BCLK;
	localparam [AW-1:0] A_EDGE = `CRS_LINT_EDGE_PULSE_BCLK;
	localparam [1:0] IRQ_HALF = `CRS_IRQCLK_HALF;
	// Reset hold never shorter than strap setup, even when shortened
	localparam [TW-1:0] T_RST_EFF = (T_RST < T_SETUP) ? T_SETUP : T_RST;

	reg [11:0] state;
	reg [11:0] next_state;
	reg t_load;
	reg [TW-1:0] t_val;
	reg mode_sleep;
	reg mode_deep;
	reg strap_drive;
	reg freeze;
	reg freeze_sleep;
	reg irq_strap_high;
	reg [1:0] irq_div;
	wire t_done;
	wire [1:0] kept_cmos;
	wire [AW-1:0] lint_min;

	// ****************************************
	// Shared delay timer
	// ****************************************
	crs_cycle_timer #(
		.W(TW)
	) u_timer (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.load_in(t_load),
		.value_in(t_val),
		.done_out(t_done)
	);

	// ****************************************
	// Next state
	// ****************************************
	always @*
	begin
		next_state = state;
		t_load = 1'b0;
		t_val = {TW{1'b0}};
		case (state)
			ST_OFF:
			begin
				if (supplies_ok_in)
				begin
					t_load = 1'b1;
					if (fast_settle_in)
					begin
						next_state = ST_RST_HOLD;
						t_val = T_RST_EFF;
					end
					else
					begin
						next_state = ST_SETTLE;
						t_val = T_PWROK;
					end
				end
			end
			ST_SETTLE:
			begin
				if (t_done)
				begin
					next_state = ST_RST_HOLD;
					t_load = 1'b1;
					t_val = T_RST_EFF;
				end
			end
			ST_RST_HOLD:
			begin
				if (t_done)
				begin
					next_state = ST_STRAP;
					t_load = 1'b1;
					t_val = T_STRAP;
				end
			end
			ST_STRAP:
			begin
				if (t_done)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (warm_reset_in)
				begin
					next_state = ST_RST_HOLD;
					t_load = 1'b1;
					t_val = T_RST_EFF;
				end
				else if (lp_req_in)
					next_state = ST_WAIT_ACK;
			end
			ST_WAIT_ACK:
			begin
				if (stop_ack_in)
				begin
					next_state = ST_ACK_GAP;
					t_load = 1'b1;
					t_val = mode_sleep ? T_ACK_SLP : T_ACK_STOP;
				end
			end
			ST_ACK_GAP:
			begin
				if (t_done)
				begin
					if (mode_sleep)
					begin
						next_state = ST_SLP_ENTER;
						t_load = 1'b1;
						t_val = T_SLP_STOP;
					end
					else
						next_state = ST_HALTED;
				end
			end
			ST_SLP_ENTER:
			begin
				if (t_done)
					next_state = ST_HALTED;
			end
			ST_HALTED:
			begin
				if (wake_in)
				begin
					t_load = 1'b1;
					if (!bclk_run_out)
					begin
						next_state = ST_PLL_LOCK;
						t_val = T_LOCK;
					end
					else if (mode_sleep)
					begin
						next_state = ST_UNSLEEP;
						t_val = T_UNSLP;
					end
					else
					begin
						next_state = ST_UNHALT;
						t_val = T_UNHALT;
					end
				end
			end
			ST_PLL_LOCK:
			begin
				if (t_done)
				begin
					t_load = 1'b1;
					if (mode_sleep)
					begin
						next_state = ST_UNSLEEP;
						t_val = T_UNSLP;
					end
					else
					begin
						next_state = ST_UNHALT;
						t_val = T_UNHALT;
					end
				end
			end
			ST_UNSLEEP:
			begin
				if (t_done)
				begin
					next_state = ST_UNHALT;
					t_load = 1'b1;
					t_val = T_UNHALT;
				end
			end
			ST_UNHALT:
			begin
				if (t_done)
					next_state = ST_RUN;
			end
			default:
			begin
				next_state = ST_OFF;
			end
		endcase
		// Supply loss overrides every state
		if (!supplies_ok_in)
		begin
			next_state = ST_OFF;
			t_load = 1'b0;
		end
	end

	// ****************************************
	// State and pin registers
	// ****************************************
	always @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			state <= ST_OFF;
			power_ok_out <= 1'b0;
			cpu_reset_n_out <= 1'b0;
			bclk_run_out <= 1'b0;
			clock_halt_request_n_out <= 1'b1;
			sleep_request_n_out <= 1'b1;
			strap_drive <= 1'b1;
			freeze <= 1'b0;
			freeze_sleep <= 1'b0;
			mode_sleep <= 1'b0;
			mode_deep <= 1'b0;
		end
		else if (ce_in)
		begin
			state <= next_state;
			if (state[4] && lp_req_in && !warm_reset_in)
			begin
				mode_sleep <= lp_sleep_in;
				mode_deep <= lp_deep_in;
			end
			power_ok_out <= ~(next_state[0] | next_state[1]);
			bclk_run_out <= ~next_state[0] & ~(next_state[8] & mode_deep);
			cpu_reset_n_out <= ~(next_state[0] | next_state[1] | next_state[2]);
			strap_drive <= |next_state[3:0];
			clock_halt_request_n_out <= ~(|next_state[10:5]);
			sleep_request_n_out <= ~(next_state[7]
				| ((next_state[8] | next_state[9]) & mode_sleep));
			// Freeze from request onward: stable before ack completes
			freeze <= |next_state[11:5];
			freeze_sleep <= (|next_state[11:5]) & mode_sleep;
		end
	end

	// ****************************************
	// Irq bus clock
	// ****************************************
	// Strap sampled at release, no reset: level caught by clock
	always @(posedge sys_clk_in)
	begin
		if (ce_in && state[2] && next_state[3])
			irq_strap_high <= strap_irq_data0_in;
	end

	// 125 MHz / 4 gives 31.25 MHz, inside the 2 to 33.3 MHz band
	always @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			irq_div <= 2'h0;
			irq_bus_clock_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (!irq_strap_high && !bclk_run_out && !strap_drive)
			begin
				irq_div <= 2'h0;
				irq_bus_clock_out <= 1'b0;
			end
			else if (irq_div == IRQ_HALF - 2'h1)
			begin
				irq_div <= 2'h0;
				irq_bus_clock_out <= ~irq_bus_clock_out;
			end
			else
				irq_div <= irq_div + 2'h1;
		end
	end

	// ****************************************
	// Processor inputs with minimum widths
	// ****************************************
	assign lint_min = lint_edge_mode_in ? A_EDGE : A_MIN;

	crs_pulse_keeper #(
		.W(2),
		.CW(AW),
		.INIT(2'h0)
	) u_lint (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.freeze_in(freeze),
		.min_in(lint_min),
		.d_in(local_irq_in),
		.q_out(local_irq_pins_out)
	);

	crs_pulse_keeper #(
		.W(2),
		.CW(AW),
		.INIT(2'h3)
	) u_cmos (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.freeze_in(freeze),
		.min_in(A_MIN),
		.d_in({cache_flush_n_in, soft_init_n_in}),
		.q_out(kept_cmos)
	);

	// Priority request may move in quick halt, never in sleep
	crs_pulse_keeper #(
		.W(1),
		.CW(AW),
		.INIT(1'b1)
	) u_prio (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.freeze_in(freeze_sleep),
		.min_in(A_MIN),
		.d_in(prio_bus_req_n_in),
		.q_out(priority_bus_request_n_out)
	);

	// ****************************************
	// Strap drive and outputs
	// ****************************************
	assign strap_address_lines_out = strap_address_in;
	assign strap_address_lines_oe_out = strap_drive;
	assign bus_request0_strap_out = strap_bus_request0_strap_in;
	assign bus_request0_strap_oe_out = strap_drive;
	assign irq_bus_data0_out = strap_irq_data0_in;
	assign irq_bus_data0_oe_out = strap_drive;
	assign cache_flush_n_out = strap_drive ? strap_flush_n_in : kept_cmos[1];
	assign soft_init_n_out = strap_drive ? strap_init_n_in : kept_cmos[0];
	assign ready_out = state[4];
	assign lp_active_out = freeze;
endmodule

// ### dv/crs_seq_props.sv
`timescale 1ns/10ps
`include "crs_map.vh"
// ****************************************
// Sequencer checker
// ****************************************
module crs_seq_props #(
	parameter RESET_HOLD_CYC = 20
) (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire fast_settle_in,
	input wire stop_ack_in,
	input wire lint_edge_mode_in,
	input wire power_ok_out,
	input wire cpu_reset_n_out,
	input wire bclk_run_out,
	input wire clock_halt_request_n_out,
	input wire sleep_request_n_out,
	input wire strap_address_lines_oe_out,
	input wire [1:0] local_irq_pins_out,
	input wire lp_active_out
);
localparam int LOCK = `CRS_PLL_LOCK_CYC;
reg ack_seen;
reg relock;
reg [7:0] ack_age;
reg [12:0] lock_age;
reg [16:0] rst_age;
// Ack and lock ages saturate so long halts never wrap
always @(posedge sys_clk_in)
begin
	rst_age <= (!rst_n_in || !power_ok_out || cpu_reset_n_out) ? 17'h00000 : rst_age + 17'h00001;
	if (!rst_n_in || clock_halt_request_n_out)
	begin
		ack_seen <= 1'b0;
		relock <= 1'b0;
		ack_age <= 8'h00;
		lock_age <= 13'h0000;
	end
	else
	begin
		ack_seen <= ack_seen | stop_ack_in;
		relock <= relock | $rose(bclk_run_out);
		ack_age <= (ack_seen && ack_age != 8'hFF) ? ack_age + 8'h01 : ack_age;
		lock_age <= (relock && lock_age != 13'h1FFF) ? lock_age + 13'h0001 : lock_age;
	end
end
default clocking cb @(posedge sys_clk_in);
endclocking
default disable iff (!rst_n_in);
sequence s_low10(sig);
	!sig[*8] ##1 !sig[*2];
endsequence
sequence s_strap_release;
	strap_address_lines_oe_out[*3] ##[1:18] !strap_address_lines_oe_out;
endsequence
AST_PWROK_LOW: assert property ($fell(power_ok_out) && !fast_settle_in |-> s_low10(power_ok_out))
	else $error("power ok low too short");
AST_PWROK_BCLK: assert property ($rose(power_ok_out) && !fast_settle_in |-> $past(bclk_run_out, 10))
	else $error("power ok before clock settled");
AST_STRAP_SETUP: assert property ($rose(cpu_reset_n_out) |-> $past(strap_address_lines_oe_out, 4))
	else $error("straps not set up");
AST_STRAP_HOLD: assert property ($rose(cpu_reset_n_out) |-> s_strap_release)
	else $error("strap hold out of range");
AST_RESET_HOLD: assert property ($rose(cpu_reset_n_out) |-> rst_age >= RESET_HOLD_CYC - 1)
	else $error("reset released early");
AST_ACK_SLEEP: assert property ($fell(sleep_request_n_out) |-> ack_seen && ack_age >= 100)
	else $error("sleep request early");
AST_ACK_STOP: assert property ($fell(bclk_run_out) && !clock_halt_request_n_out |-> ack_age >= 100)
	else $error("clock stopped early");
AST_SLEEP_STOP: assert property ($fell(bclk_run_out) && !sleep_request_n_out |-> !$past(sleep_request_n_out, 10))
	else $error("clock stopped soon after sleep");
AST_HALT_LOCK: assert property ($rose(clock_halt_request_n_out) && relock |-> lock_age >= LOCK - 1)
	else $error("halt released before lock");
AST_UNSLEEP_HALT: assert property ($rose(sleep_request_n_out) |-> s_low10(clock_halt_request_n_out))
	else $error("halt released soon after sleep");
AST_UNHALT_HOLD: assert property ($rose(clock_halt_request_n_out) |-> $stable(local_irq_pins_out)[*8])
	else $error("pins moved after halt release");
AST_FROZEN: assert property (lp_active_out && $past(lp_active_out) |-> $stable(local_irq_pins_out))
	else $error("pins moved while halted");
AST_LINT_EDGE: assert property ($changed(local_irq_pins_out[0]) && lint_edge_mode_in |=> $stable(local_irq_pins_out[0])[*5])
	else $error("irq pulse too short");
endmodule
bind crs_sequencer crs_seq_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) crs_seq_props_inst (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .fast_settle_in(fast_settle_in),
	.stop_ack_in(stop_ack_in), .lint_edge_mode_in(lint_edge_mode_in), .power_ok_out(power_ok_out),
	.cpu_reset_n_out(cpu_reset_n_out), .bclk_run_out(bclk_run_out),
	.clock_halt_request_n_out(clock_halt_request_n_out), .sleep_request_n_out(sleep_request_n_out),
	.strap_address_lines_oe_out(strap_address_lines_oe_out),
	.local_irq_pins_out(local_irq_pins_out), .lp_active_out(lp_active_out)
);

// ### dv/crs_cpu_model.sv
`timescale 1ns/10ps
// ****************************************
// Processor side model
// ****************************************
module crs_cpu_model (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire halt_n_in,
	input wire bclk_in,
	input wire slow_in,
	output reg ack_out = 1'b0,
	output reg locked_out = 1'b0
);
integer wait_cnt = 0;
integer lock_cnt = 0;
wire [5:0] ack_at = slow_in ? 6'h28 : 6'h03;
// Locks well inside the limit, so a fixed wait is safe
always @(posedge sys_clk_in)
begin
	wait_cnt <= (!rst_n_in || halt_n_in) ? 32'h0 : wait_cnt + 32'h1;
	ack_out <= !halt_n_in && wait_cnt >= ack_at && wait_cnt < ack_at + 6'h02;
	lock_cnt <= !bclk_in ? 32'h0 : (lock_cnt < 32'hBB8 ? lock_cnt + 32'h1 : lock_cnt);
	locked_out <= bclk_in && lock_cnt >= 32'hBB8;
end
endmodule

// ### dv/cpu_reset_and_sleep_sequencer_bench.sv
`timescale 1ns/10ps
module cpu_reset_and_sleep_sequencer_bench;
// ****************************************
// Signals and instances
// ****************************************
localparam HOLD = 20;
reg sys_clk_in;
reg rst_n_in = 1'b0;
reg supplies_ok_in = 1'b0;
reg fast_settle_in = 1'b0;
reg warm_reset_in = 1'b0;
reg lp_req_in = 1'b0;
reg lp_sleep_in = 1'b0;
reg lp_deep_in = 1'b0;
reg wake_in = 1'b0;
reg slow_ack = 1'b0;
reg [10:0] strap_address_in = 11'h000;
reg [9:0] drv = 10'h276;
reg [1:0] held;
integer miscompares = 0;
integer total_checks = 0;
integer n;
integer i;
wire power_ok_out, cpu_reset_n_out, bclk_run_out, ready_out, lp_active_out, stop_ack_in, locked;
wire clock_halt_request_n_out, sleep_request_n_out, strap_address_lines_oe_out;
wire [10:0] strap_address_lines_out;
wire [1:0] local_irq_pins_out;
wire cache_flush_n_out, soft_init_n_out, priority_bus_request_n_out, irq_bus_clock_out;
wire bus_request0_strap_out, bus_request0_strap_oe_out, irq_bus_data0_out, irq_bus_data0_oe_out;
wire [9:0] ev = {!power_ok_out, !cpu_reset_n_out, clock_halt_request_n_out, sleep_request_n_out,
	!strap_address_lines_oe_out, !sleep_request_n_out, power_ok_out, cpu_reset_n_out,
	!clock_halt_request_n_out, ready_out};
crs_sequencer #(.RESET_HOLD_CYC(HOLD)) crs_sequencer_inst (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .supplies_ok_in(supplies_ok_in),
	.fast_settle_in(fast_settle_in), .warm_reset_in(warm_reset_in), .lp_req_in(lp_req_in),
	.lp_sleep_in(lp_sleep_in), .lp_deep_in(lp_deep_in), .wake_in(wake_in),
	.stop_ack_in(stop_ack_in), .strap_address_in(strap_address_in), .strap_bus_request0_strap_in(drv[0]),
	.strap_flush_n_in(drv[1]), .strap_init_n_in(drv[2]), .strap_irq_data0_in(drv[3]),
	.cache_flush_n_in(drv[4]), .soft_init_n_in(drv[5]), .prio_bus_req_n_in(drv[6]),
	.local_irq_in(drv[8:7]), .lint_edge_mode_in(drv[9]), .power_ok_out(power_ok_out),
	.cpu_reset_n_out(cpu_reset_n_out), .bclk_run_out(bclk_run_out),
	.clock_halt_request_n_out(clock_halt_request_n_out), .sleep_request_n_out(sleep_request_n_out),
	.strap_address_lines_out(strap_address_lines_out),
	.bus_request0_strap_out(bus_request0_strap_out),
	.strap_address_lines_oe_out(strap_address_lines_oe_out),
	.bus_request0_strap_oe_out(bus_request0_strap_oe_out),
	.irq_bus_data0_out(irq_bus_data0_out), .irq_bus_data0_oe_out(irq_bus_data0_oe_out),
	.cache_flush_n_out(cache_flush_n_out), .soft_init_n_out(soft_init_n_out),
	.priority_bus_request_n_out(priority_bus_request_n_out),
	.local_irq_pins_out(local_irq_pins_out),
	.irq_bus_clock_out(irq_bus_clock_out), .ready_out(ready_out), .lp_active_out(lp_active_out)
);
crs_cpu_model crs_cpu_model_inst (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .halt_n_in(clock_halt_request_n_out),
	.bclk_in(bclk_run_out), .slow_in(slow_ack), .ack_out(stop_ack_in), .locked_out(locked)
);
// ****************************************
// Helpers
// ****************************************
task check(input [31:0] seen, input [31:0] exp);
begin
	total_checks = total_checks + 1;
	if (seen !== exp)
	begin
		miscompares = miscompares + 1;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
	end
end
endtask
// Bounded wait, counting edges until the event shows
task wait_for(input integer sel, output integer cnt);
begin
	cnt = 0;
	while (ev[sel] !== 1'b1 && cnt < 5000)
	begin
		@(posedge sys_clk_in);
		#1;
		cnt = cnt + 1;
	end
	if (cnt >= 5000)
		check(1, 0);
end
endtask
task tally_and_finish;
begin
	if (miscompares == 0 && total_checks > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
end
endtask
initial
begin
	sys_clk_in = 1'b0;
	forever #4 sys_clk_in = ~sys_clk_in;
end
initial
begin
	#(40000 * 8);
	miscompares = miscompares + 1;
	tally_and_finish;
end
// ****************************************
// Scenarios
// ****************************************
initial
begin
	void'($urandom(32'hC592));
	repeat (4) @(posedge sys_clk_in);
	rst_n_in <= 1'b1;
	strap_address_in <= 11'($urandom);
	drv <= {1'b1, 9'($urandom)};
	@(posedge sys_clk_in);
	supplies_ok_in <= 1'b1;
	wait_for(3, n);
	check(n >= 11, 1);
	wait_for(2, n);
	check(n >= HOLD, 1);
	check({strap_address_lines_oe_out, strap_address_lines_out}, {1'b1, strap_address_in});
	check({bus_request0_strap_oe_out, irq_bus_data0_oe_out, bus_request0_strap_out,
		irq_bus_data0_out, cache_flush_n_out, soft_init_n_out},
		{2'h3, drv[0], drv[3], drv[1], drv[2]});
	wait_for(5, n);
	check(n >= 2 && n <= 20, 1);
	check({bus_request0_strap_oe_out, irq_bus_data0_oe_out}, 2'h0);
	wait_for(0, n);
	repeat (40)
	begin
		@(posedge sys_clk_in);
		drv <= {drv[9], 9'($urandom)};
	end
	repeat (8) @(posedge sys_clk_in);
	#1;
	check(local_irq_pins_out, drv[8:7]);
	check({cache_flush_n_out, soft_init_n_out, priority_bus_request_n_out},
		{drv[4], drv[5], drv[6]});
	held[0] = irq_bus_clock_out;
	repeat (2) @(posedge sys_clk_in);
	#1;
	check(irq_bus_clock_out, !held[0]);
	for (i = 0; i < 4; i = i + 1)
	begin
		@(posedge sys_clk_in);
		lp_req_in <= 1'b1;
		lp_sleep_in <= i[0];
		lp_deep_in <= i[1];
		slow_ack <= 1'($urandom);
		@(posedge sys_clk_in);
		lp_req_in <= 1'b0;
		wait_for(1, n);
		held = local_irq_pins_out;
		@(posedge sys_clk_in);
		drv[8:7] <= ~held;
		wake_in <= 1'b1;
		if (i[0])
		begin
			wait_for(4, n);
			wait_for(6, n);
			check(locked || !i[1], 1);
		end
		wait_for(7, n);
		check(n >= 10 || !i[0], 1);
		check(locked || !i[1], 1);
		check(local_irq_pins_out, held);
		@(posedge sys_clk_in);
		wake_in <= 1'b0;
		wait_for(0, n);
	end
	@(posedge sys_clk_in);
	warm_reset_in <= 1'b1;
	@(posedge sys_clk_in);
	warm_reset_in <= 1'b0;
	wait_for(8, n);
	wait_for(2, n);
	check({power_ok_out, strap_address_lines_oe_out}, 2'h3);
	wait_for(0, n);
	for (i = 0; i < 2; i = i + 1)
	begin
		@(posedge sys_clk_in);
		supplies_ok_in <= 1'b0;
		fast_settle_in <= i[0];
		wait_for(9, n);
		@(posedge sys_clk_in);
		supplies_ok_in <= 1'b1;
		wait_for(3, n);
		check(i[0] ? n <= 2 : n >= 11, 1);
		check(bclk_run_out, 1);
		wait_for(0, n);
	end
	tally_and_finish;
end
endmodule
